// [bench/acd_core_test.sv]
// Self-checking bench for the command code decoder.
`timescale 1ns/1ns
`default_nettype none
`include "acd_params.svh"
module acd_core_test import acd_pkg::*;;
   logic clk, rst_n, cs_n, wr_n, rd_n, oe, done, start, retry, lba, busy;
   logic [9:0]  addr;
   logic [7:0]  din, dout, feat, cnt, v;
   logic [27:0] eaddr, caddr;
   acd_op_e     op;
   int          num_errors = 0;
   int          n_tests = 0;
   logic [7:0]  codes[35] = '{8'h20, 8'h30, 8'h40, 8'hC8, 8'hCA, 8'hC4, 8'hC5, 8'h3C,
      8'h1F, 8'h7A, 8'h91, 8'h90, 8'h50, 8'h22, 8'h33, 8'hEC, 8'hEE, 8'hEF, 8'hC6,
      8'hE4, 8'hE8, 8'hB0, 8'hE7, 8'h97, 8'hE3, 8'h95, 8'hE1, 8'h96, 8'hE2, 8'h94,
      8'hE0, 8'h99, 8'hE6, 8'h98, 8'hE5};
   acd_op_e     ops[35] = '{ACD_OP_RD_SEC, ACD_OP_WR_SEC, ACD_OP_RD_VERIFY, ACD_OP_RD_DMA,
      ACD_OP_WR_DMA, ACD_OP_RD_MULT, ACD_OP_WR_MULT, ACD_OP_WR_VERIFY, ACD_OP_RECAL,
      ACD_OP_SEEK, ACD_OP_INIT_PARAM, ACD_OP_DIAG, ACD_OP_FORMAT, ACD_OP_RD_LONG,
      ACD_OP_WR_LONG, ACD_OP_IDENT, ACD_OP_IDENT_DMA, ACD_OP_SET_FEAT, ACD_OP_SET_MULT,
      ACD_OP_RD_BUF, ACD_OP_WR_BUF, ACD_OP_SMART, ACD_OP_FLUSH, ACD_OP_IDLE, ACD_OP_IDLE,
      ACD_OP_IDLE_NOW, ACD_OP_IDLE_NOW, ACD_OP_STANDBY, ACD_OP_STANDBY, ACD_OP_STANDBY_NOW,
      ACD_OP_STANDBY_NOW, ACD_OP_SLEEP, ACD_OP_SLEEP, ACD_OP_CHK_POWER, ACD_OP_CHK_POWER};
   acd_host_model host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
      .data(din), .rdata(dout));
   acd_core uut (.clk(clk), .rst_n(rst_n), .host_cs_n(cs_n), .host_wr_n(wr_n),
      .host_rd_n(rd_n), .host_addr(addr), .host_data_in(din), .host_data_out(dout),
      .host_data_oe(oe), .drive_ready(1'b1), .cmd_done(done), .cmd_fail(1'b0),
      .cmd_fault_code(8'h00), .end_addr(eaddr), .remain_count(8'h00), .cmd_start(start),
      .cmd_op(op), .cmd_retry(retry), .cmd_lba_mode(lba), .cmd_feature(feat),
      .cmd_count(cnt), .cmd_addr(caddr), .cmd_busy(busy));
   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // A command that never raises busy would hang the bench, so the wait is bounded.
   task automatic wait_busy;
      for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
      check(busy, 1'b1);
      if (busy !== 1'b1) report_and_stop();
   endtask
   task automatic finish_cmd(input logic [27:0] ea);
      @(posedge clk) #1;
      {done, eaddr} = {1'b1, ea};
      @(posedge clk) #1 done = 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic lba_read;
      host.put(`ACD_OFF_FEATURE, 8'hC3);
      host.cmd(8'h05, 8'h11, 8'h22, 8'h33, 8'h4A, 8'h21);
      wait_busy();
      check(feat, 8'h00);
      check(caddr, 28'hA332211);
      check({lba, retry, cnt}, {2'b10, 8'h05});
      finish_cmd(28'h1234567);
      // The output enable is sampled while the read strobe is still held.
      fork
         host.get(`ACD_OFF_COUNT, v);
         begin
            repeat (5) @(posedge clk);
            #1 check(oe, 1'b1);
         end
      join
      check(v, `ACD_COUNT_DONE);
      host.get(`ACD_OFF_TRK_HIGH, v);
      check(v, 8'h23);
   endtask
   task automatic all_codes;
      for (int k = 0; k < 35; k++)
      begin
         host.cmd(8'h77, 8'h11, 8'h22, 8'h33, 8'h0F, codes[k]);
         wait_busy();
         check(op, ops[k]);
         check(retry, codes[k] inside {8'h20, 8'h30, 8'h40, 8'hC8, 8'hCA, 8'h22});
         check(feat, (codes[k] inside {8'hEF, 8'hB0}) ? 8'hC3 : 8'h00);
         if (codes[k] == 8'h1F)
         begin
            check(cnt, 8'h00);
            check(caddr, 28'h0);
         end
         finish_cmd(28'h0000001);
      end
   endtask
   task automatic bad_code;
      host.put(`ACD_OFF_COUNT, 8'h5A);
      host.put(`ACD_OFF_OPCODE, 8'hFF);
      repeat (4) @(posedge clk);
      check(busy, 1'b0);
      host.get(`ACD_OFF_FEATURE, v);
      check(v, `ACD_ERR_ABORT);
      host.get(`ACD_OFF_OPCODE, v);
      check(v, 8'h51);
      host.get(`ACD_OFF_COUNT, v);
      check(v, 8'h5A);
   endtask
   // Free-running clock at 50 ns; reset held for six edges.
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      {rst_n, done, eaddr} = '0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      lba_read();
      all_codes();
      bad_code();
      report_and_stop();
   end
endmodule
`default_nettype wire

// [bench/acd_host_model.sv]
// Host model that drives the task-file register port of the decoder.
`timescale 1ns/1ns
`default_nettype none
`include "acd_params.svh"
module acd_host_model
(
   input  wire logic       clk,
   output logic            cs_n,
   output logic            wr_n,
   output logic            rd_n,
   output logic [9:0]      addr,
   output logic [7:0]      data,
   input  wire logic [7:0] rdata
);
   // The port idles deselected with both strobes high.
   initial
   begin
      {cs_n, wr_n, rd_n, addr, data} = `ACD_HOST_IDLE;
   end
   // Strobes stay long enough for the two-stage synchroniser to see them.
   task automatic put(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      {cs_n, addr, data, wr_n} = {1'b0, a, d, 1'b0};
      repeat (3) @(posedge clk);
      #1 wr_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 cs_n = 1'b1;
      data = ~d; // A released bus must not keep showing the last value.
   endtask
   task automatic get(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      {cs_n, addr, rd_n} = {1'b0, a, 1'b0};
      repeat (6) @(posedge clk);
      #1 d = rdata;
      {cs_n, rd_n} = 2'b11;
      repeat (4) @(posedge clk);
   endtask
   // Parameters first, opcode last; diagnostic always goes to the master.
   task automatic cmd(input logic [7:0] sc, sn, cl, ch, dh, c);
      put(`ACD_OFF_COUNT, sc);
      put(`ACD_OFF_SECTOR, sn);
      put(`ACD_OFF_TRK_LOW, cl);
      put(`ACD_OFF_TRK_HIGH, ch);
      put(`ACD_OFF_UNIT_HEAD, (c == 8'h90) ? (dh & 8'hEF) : dh);
      put(`ACD_OFF_OPCODE, c);
   endtask
endmodule
`default_nettype wire

// [rtl/acd_core.sv]
// Task-file register block with command code decoding for the drive controller.
`timescale 1ns/1ns
`default_nettype none
`include "acd_params.svh"

module acd_core
   import acd_pkg::*;
#(
   parameter logic UNIT_ID = 1'b0
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        host_cs_n,
   input  wire logic        host_wr_n,
   input  wire logic        host_rd_n,
   input  wire logic [9:0]  host_addr,
   input  wire logic [7:0]  host_data_in,
   output logic      [7:0]  host_data_out,
   output logic             host_data_oe,
   input  wire logic        drive_ready,
   input  wire logic        cmd_done,
   input  wire logic        cmd_fail,
   input  wire logic [7:0]  cmd_fault_code,
   input  wire logic [27:0] end_addr,
   input  wire logic [7:0]  remain_count,
   output logic             cmd_start,
   output acd_op_e          cmd_op,
   output logic             cmd_retry,
   output logic             cmd_lba_mode,
   output logic [7:0]       cmd_feature,
   output logic [7:0]       cmd_count,
   output logic [27:0]      cmd_addr,
   output logic             cmd_busy
);

   acd_state_s   q;
   acd_state_s   n;
   acd_host_in_s pins;
   acd_host_in_s hs;
   acd_dec_s     dec;
   logic         wr_take;
   logic         code_wr;
   logic         unit_hit;
   logic [7:0]   status;

   // ----------------------------------------------------------------------------
   // Pin synchronisation and decoding
   // ----------------------------------------------------------------------------
   // Host strobes are asynchronous, so the whole bundle crosses through two stages.
   assign pins = '{cs_n: host_cs_n, wr_n: host_wr_n, rd_n: host_rd_n,
                   addr: host_addr, data: host_data_in};

   acd_sync #(
      .WIDTH ($bits(acd_host_in_s)),
      .INIT  (`ACD_HOST_IDLE)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (pins),
      .dout  (hs)
   );

   acd_decode u_decode (
      .code (hs.data),
      .dec  (dec)
   );

   // A write commits on the rising edge of the write strobe, when data is settled.
   assign wr_take  = hs.wr_n && !q.wr_n_prev && !hs.cs_n;
   assign code_wr  = wr_take && (hs.addr == `ACD_OFF_OPCODE) && (q.fsm == ACD_ST_IDLE);
   assign unit_hit = (q.unit_and_head_select[`ACD_UH_DEV_BIT] == UNIT_ID) ||
                     dec.use_map.any_unit;
   assign status   = {q.fsm == ACD_ST_BUSY, drive_ready, 1'b0, drive_ready,
                      1'b0, 2'b00, q.err_flag};

   // ----------------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------------
   always_comb
   begin
      n           = q;
      n.wr_n_prev = hs.wr_n;
      n.start     = 1'b0;
      // Parameter writes are refused while busy, as the command block is frozen.
      if (wr_take && q.fsm == ACD_ST_IDLE)
      begin
         case (hs.addr)
            `ACD_OFF_FEATURE:   n.feature_select_in     = hs.data;
            `ACD_OFF_COUNT:     n.transfer_sector_count = hs.data;
            `ACD_OFF_SECTOR:    n.start_sector_index    = hs.data;
            `ACD_OFF_TRK_LOW:   n.track_address_low     = hs.data;
            `ACD_OFF_TRK_HIGH:  n.track_address_high    = hs.data;
            `ACD_OFF_UNIT_HEAD: n.unit_and_head_select  = hs.data;
            default:            n.wr_n_prev             = hs.wr_n;
         endcase
      end
      // A command for the other unit is silently left to that unit.
      if (code_wr && unit_hit)
      begin
         if (dec.valid)
         begin
            n.fsm      = ACD_ST_BUSY;
            n.start    = 1'b1;
            n.op       = dec.op;
            n.retry    = dec.retry;
            n.err_flag = 1'b0;
            n.fault_cause_out = `ACD_REG_RESET;
            n.lba_mode = q.unit_and_head_select[`ACD_UH_LBA_BIT];
            // Unused registers are zeroed toward the engine so stale values never leak.
            n.feature  = dec.use_map.feature ? q.feature_select_in : 8'h00;
            n.count    = dec.use_map.count ? q.transfer_sector_count : 8'h00;
            n.addr[27:24] = dec.use_map.head ?
                            q.unit_and_head_select[`ACD_UH_HEAD_MSB:0] : 4'h0;
            n.addr[23:8]  = dec.use_map.track ?
                            {q.track_address_high, q.track_address_low} : 16'h0000;
            n.addr[7:0]   = (dec.use_map.sector && (!dec.use_map.sector_lba_only ||
                            q.unit_and_head_select[`ACD_UH_LBA_BIT])) ?
                            q.start_sector_index : 8'h00;
         end
         else
         begin
            n.err_flag        = 1'b1;
            n.fault_cause_out = `ACD_ERR_ABORT;
         end
      end
      // ----------------------------------------------------------------------------
      // Completion from the drive engine
      // ----------------------------------------------------------------------------
      case (q.fsm)
         ACD_ST_IDLE:
         begin
            n.start = n.start;
         end
         ACD_ST_BUSY:
         begin
            if (cmd_done)
            begin
               n.fsm                   = ACD_ST_IDLE;
               n.err_flag              = cmd_fail;
               n.fault_cause_out       = cmd_fail ? cmd_fault_code : `ACD_REG_RESET;
               n.transfer_sector_count = cmd_fail ? remain_count : `ACD_COUNT_DONE;
               n.start_sector_index    = end_addr[7:0];
               n.track_address_low     = end_addr[15:8];
               n.track_address_high    = end_addr[23:16];
               n.unit_and_head_select[`ACD_UH_HEAD_MSB:0] = end_addr[27:24];
            end
         end
         default:
         begin
            n.fsm = ACD_ST_IDLE;
         end
      endcase
      // ----------------------------------------------------------------------------
      // Host read path
      // ----------------------------------------------------------------------------
      // While busy every command-block read shows status, the only safe value then.
      n.data_oe = !hs.rd_n && !hs.cs_n;
      if (q.fsm == ACD_ST_BUSY)
      begin
         n.rdata = status;
      end
      else
      begin
         case (hs.addr)
            `ACD_OFF_FEATURE:   n.rdata = q.fault_cause_out;
            `ACD_OFF_COUNT:     n.rdata = q.transfer_sector_count;
            `ACD_OFF_SECTOR:    n.rdata = q.start_sector_index;
            `ACD_OFF_TRK_LOW:   n.rdata = q.track_address_low;
            `ACD_OFF_TRK_HIGH:  n.rdata = q.track_address_high;
            `ACD_OFF_UNIT_HEAD: n.rdata = q.unit_and_head_select;
            `ACD_OFF_OPCODE:    n.rdata = status;
            default:            n.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q           <= '0;
         q.fsm       <= ACD_ST_IDLE;
         q.wr_n_prev <= 1'b1;
         q.op        <= ACD_OP_NONE;
      end
      else
      begin
         q <= n;
      end
   end

   assign host_data_out = q.rdata;
   assign host_data_oe  = q.data_oe;
   assign cmd_start     = q.start;
   assign cmd_op        = q.op;
   assign cmd_retry     = q.retry;
   assign cmd_lba_mode  = q.lba_mode;
   assign cmd_feature   = q.feature;
   assign cmd_count     = q.count;
   assign cmd_addr      = q.addr;
   assign cmd_busy      = q.fsm[1];     // One-hot code: bit 1 is the busy state flop.

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   property p_start_follows_code;
      @(posedge clk) disable iff (!rst_n)
      code_wr && unit_hit && dec.valid |=> cmd_start && cmd_busy;
   endproperty
   a_start_follows_code: assert property (p_start_follows_code)
      else $error("Valid command write did not start the engine.");

   property p_retry_bit;
      @(posedge clk) disable iff (!rst_n)
      code_wr && unit_hit && hs.data[7:1] == 7'h10 |=> cmd_retry == !$past(hs.data[0]);
   endproperty
   a_retry_bit: assert property (p_retry_bit)
      else $error("Retry selection does not follow the code bit.");

   property p_recal_nibble;
      @(posedge clk) disable iff (!rst_n)
      code_wr && unit_hit && hs.data[7:4] == 4'h1 |=> cmd_op == ACD_OP_RECAL;
   endproperty
   a_recal_nibble: assert property (p_recal_nibble)
      else $error("Upper nibble one was not taken as recalibrate.");

   property p_power_pair;
      @(posedge clk) disable iff (!rst_n)
      code_wr && unit_hit && (hs.data == 8'h99 || hs.data == 8'hE6) |=> cmd_op == ACD_OP_SLEEP;
   endproperty
   a_power_pair: assert property (p_power_pair)
      else $error("Sleep code pair not decoded alike.");

   property p_head_ignored;
      @(posedge clk) disable iff (!rst_n)
      cmd_start && (cmd_op == ACD_OP_IDENT || cmd_op == ACD_OP_SET_FEAT) |->
         cmd_addr[27:24] == 4'h0;
   endproperty
   a_head_ignored: assert property (p_head_ignored)
      else $error("Head field reached the engine for a device-only command.");

   property p_unused_zero;
      @(posedge clk) disable iff (!rst_n)
      cmd_start && cmd_op == ACD_OP_RECAL |-> cmd_count == 8'h00 && cmd_feature == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("Unused parameter passed to the engine.");

   property p_lba_layout;
      @(posedge clk) disable iff (!rst_n)
      cmd_start && cmd_op == ACD_OP_RD_SEC |->
         cmd_addr == {q.unit_and_head_select[3:0], q.track_address_high,
                      q.track_address_low, q.start_sector_index} &&
         cmd_lba_mode == q.unit_and_head_select[6];
   endproperty
   a_lba_layout: assert property (p_lba_layout)
      else $error("Address not assembled from head, track and sector.");

   property p_count_cleared;
      @(posedge clk) disable iff (!rst_n)
      cmd_busy && cmd_done && !cmd_fail |=> q.transfer_sector_count == 8'h00 && !cmd_busy;
   endproperty
   a_count_cleared: assert property (p_count_cleared)
      else $error("Sector count not zero after success.");

   property p_abort;
      @(posedge clk) disable iff (!rst_n)
      code_wr && unit_hit && !dec.valid |=>
         q.fault_cause_out == 8'h04 && q.err_flag && !cmd_start && $stable(cmd_addr);
   endproperty
   a_abort: assert property (p_abort)
      else $error("Unknown code not aborted cleanly.");

   // The diagnostic must start here whatever unit the select bit names.
   property p_diag_any_unit;
      @(posedge clk) disable iff (!rst_n)
      code_wr && hs.data == 8'h90 |=> cmd_start && cmd_op == ACD_OP_DIAG;
   endproperty
   a_diag_any_unit: assert property (p_diag_any_unit)
      else $error("Diagnostic was not executed by this unit.");

   property p_feature_pass;
      @(posedge clk) disable iff (!rst_n)
      code_wr && unit_hit && hs.data == 8'hEF |=> cmd_feature == $past(q.feature_select_in);
   endproperty
   a_feature_pass: assert property (p_feature_pass)
      else $error("Set features did not pass the feature value.");

endmodule
`default_nettype wire

// [rtl/acd_decode.sv]
// Command code decoder: operation, retry choice and parameter usage per code.
`timescale 1ns/1ns
`default_nettype none
`include "acd_params.svh"

module acd_decode
   import acd_pkg::*;
(
   input  wire logic [7:0] code,
   output acd_dec_s        dec
);

   // ----------------------------------------------------------------------------
   // Code table
   // ----------------------------------------------------------------------------
   // Codes carrying a retry-select bit set retry when that bit is clear.
   always_comb
   begin
      dec         = '0;
      dec.valid   = 1'b1;
      dec.retry   = 1'b0;
      dec.use_map = `ACD_USE_SECT;
      casez (code)
         8'h20, 8'h21: dec.op = ACD_OP_RD_SEC;
         8'h30, 8'h31: dec.op = ACD_OP_WR_SEC;
         8'h40, 8'h41: dec.op = ACD_OP_RD_VERIFY;
         8'hC8, 8'hC9: dec.op = ACD_OP_RD_DMA;
         8'hCA, 8'hCB: dec.op = ACD_OP_WR_DMA;
         8'hC4:        dec.op = ACD_OP_RD_MULT;
         8'hC5:        dec.op = ACD_OP_WR_MULT;
         8'h3C:        dec.op = ACD_OP_WR_VERIFY;
         8'h22, 8'h23: dec.op = ACD_OP_RD_LONG;
         8'h32, 8'h33: dec.op = ACD_OP_WR_LONG;
         8'h1?:
         begin
            dec.op      = ACD_OP_RECAL;
            dec.use_map = `ACD_USE_NONE;
         end
         8'h7?:
         begin
            dec.op      = ACD_OP_SEEK;
            dec.use_map = `ACD_USE_SEEK;
         end
         8'h91:
         begin
            dec.op      = ACD_OP_INIT_PARAM;
            dec.use_map = `ACD_USE_INIT;
         end
         8'h90:
         begin
            dec.op      = ACD_OP_DIAG;
            dec.use_map = `ACD_USE_DIAG;
         end
         8'h50:
         begin
            dec.op      = ACD_OP_FORMAT;
            dec.use_map = `ACD_USE_FMT;
         end
         8'hEC, 8'hEE, 8'hE4, 8'hE8, 8'hE7:
         begin
            dec.op      = (code == 8'hEC) ? ACD_OP_IDENT :
                          (code == 8'hEE) ? ACD_OP_IDENT_DMA :
                          (code == 8'hE4) ? ACD_OP_RD_BUF :
                          (code == 8'hE8) ? ACD_OP_WR_BUF : ACD_OP_FLUSH;
            dec.use_map = `ACD_USE_NONE;
         end
         8'hEF:
         begin
            dec.op      = ACD_OP_SET_FEAT;
            dec.use_map = `ACD_USE_SETF;
         end
         8'hC6:
         begin
            dec.op      = ACD_OP_SET_MULT;
            dec.use_map = `ACD_USE_COUNT;
         end
         8'hB0:
         begin
            dec.op      = ACD_OP_SMART;
            dec.use_map = `ACD_USE_SMART;
         end
         8'h97, 8'hE3, 8'h96, 8'hE2:
         begin
            dec.op      = code[0] ? ACD_OP_IDLE : ACD_OP_STANDBY;
            dec.use_map = `ACD_USE_COUNT;
         end
         8'h95, 8'hE1, 8'h94, 8'hE0, 8'h99, 8'hE6, 8'h98, 8'hE5:
         begin
            dec.op      = (code == 8'h95 || code == 8'hE1) ? ACD_OP_IDLE_NOW :
                          (code == 8'h94 || code == 8'hE0) ? ACD_OP_STANDBY_NOW :
                          (code == 8'h99 || code == 8'hE6) ? ACD_OP_SLEEP : ACD_OP_CHK_POWER;
            dec.use_map = `ACD_USE_NONE;
         end
         default:
         begin
            dec.valid   = 1'b0;
            dec.op      = ACD_OP_NONE;
            dec.use_map = `ACD_USE_NONE;
         end
      endcase
      // Only the paired sector, read verify, long and DMA codes carry the retry-select bit.
      if (code[7:1] == 7'h10 || code[7:1] == 7'h18 || code[7:1] == 7'h20 ||
          code[7:1] == 7'h64 || code[7:1] == 7'h65 || code[7:1] == 7'h11 ||
          code[7:1] == 7'h19)
      begin
         dec.retry = ~code[`ACD_RETRY_BIT];
      end
   end

endmodule
`default_nettype wire

// [rtl/acd_params.svh]
// Offsets, field positions, reset values and usage masks of the command code decoder.
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Task-file register offsets on the host port
// ----------------------------------------------------------------------------
`define ACD_OFF_FEATURE   10'h1F1
`define ACD_OFF_COUNT     10'h1F2
`define ACD_OFF_SECTOR    10'h1F3
`define ACD_OFF_TRK_LOW   10'h1F4
`define ACD_OFF_TRK_HIGH  10'h1F5
`define ACD_OFF_UNIT_HEAD 10'h1F6
`define ACD_OFF_OPCODE    10'h1F7

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define ACD_UH_LBA_BIT    6
`define ACD_UH_DEV_BIT    4
`define ACD_UH_HEAD_MSB   3
`define ACD_RETRY_BIT     0
`define ACD_ERR_ABORT     8'h04
`define ACD_REG_RESET     8'h00
`define ACD_COUNT_DONE    8'h00
`define ACD_HOST_IDLE     21'h1C0000

// ----------------------------------------------------------------------------
// Parameter usage masks: {feature, count, sector, track, head, sector_lba_only, any_unit}
// ----------------------------------------------------------------------------
`define ACD_USE_SECT      7'b0111100
`define ACD_USE_NONE      7'b0000000
`define ACD_USE_SEEK      7'b0011100
`define ACD_USE_INIT      7'b0100100
`define ACD_USE_DIAG      7'b0000001
`define ACD_USE_FMT       7'b0011110
`define ACD_USE_SETF      7'b1100000
`define ACD_USE_COUNT     7'b0100000
`define ACD_USE_SMART     7'b1111000

`endif

// [rtl/acd_pkg.sv]
// Types shared by the command code decoder files.
package acd_pkg;

   typedef enum logic [4:0] {
      ACD_OP_NONE, ACD_OP_RD_SEC, ACD_OP_WR_SEC, ACD_OP_RD_VERIFY, ACD_OP_RD_DMA,
      ACD_OP_WR_DMA, ACD_OP_RD_MULT, ACD_OP_WR_MULT, ACD_OP_WR_VERIFY, ACD_OP_RECAL,
      ACD_OP_SEEK, ACD_OP_INIT_PARAM, ACD_OP_DIAG, ACD_OP_FORMAT, ACD_OP_RD_LONG,
      ACD_OP_WR_LONG, ACD_OP_IDENT, ACD_OP_IDENT_DMA, ACD_OP_SET_FEAT, ACD_OP_SET_MULT,
      ACD_OP_RD_BUF, ACD_OP_WR_BUF, ACD_OP_SMART, ACD_OP_FLUSH, ACD_OP_IDLE,
      ACD_OP_IDLE_NOW, ACD_OP_STANDBY, ACD_OP_STANDBY_NOW, ACD_OP_SLEEP, ACD_OP_CHK_POWER
   } acd_op_e;

   typedef enum logic [1:0] {
      ACD_ST_IDLE = 2'b01,
      ACD_ST_BUSY = 2'b10
   } acd_fsm_e;

   typedef struct packed {
      logic feature;
      logic count;
      logic sector;
      logic track;
      logic head;
      logic sector_lba_only;
      logic any_unit;
   } acd_use_s;

   typedef struct packed {
      logic     valid;
      acd_op_e  op;
      logic     retry;
      acd_use_s use_map;
   } acd_dec_s;

   typedef struct packed {
      logic       cs_n;
      logic       wr_n;
      logic       rd_n;
      logic [9:0] addr;
      logic [7:0] data;
   } acd_host_in_s;

   typedef struct packed {
      acd_fsm_e    fsm;
      logic        wr_n_prev;
      logic [7:0]  feature_select_in;
      logic [7:0]  transfer_sector_count;
      logic [7:0]  start_sector_index;
      logic [7:0]  track_address_low;
      logic [7:0]  track_address_high;
      logic [7:0]  unit_and_head_select;
      logic [7:0]  fault_cause_out;
      logic        err_flag;
      acd_op_e     op;
      logic        retry;
      logic        lba_mode;
      logic [7:0]  feature;
      logic [7:0]  count;
      logic [27:0] addr;
      logic        start;
      logic [7:0]  rdata;
      logic        data_oe;
   } acd_state_s;

endpackage

// [rtl/acd_sync.sv]
// Two-stage synchroniser for the host pin bundle.
`timescale 1ns/1ns
`default_nettype none

module acd_sync
   import acd_pkg::*;
#(
   parameter int               WIDTH = 21,
   parameter logic [WIDTH-1:0] INIT  = '0
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_reg;

   // ----------------------------------------------------------------------------
   // Synchroniser stages
   // ----------------------------------------------------------------------------
   // The first stage feeds only the second, so a metastable level never fans out.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_reg <= INIT;
         dout     <= INIT;
      end
      else
      begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end

endmodule
`default_nettype wire
